// ---- rtl/mhp_defs.svh ----
// constants for the multidrop host-link command parser
// Operation
// - check byte is XOR of all block characters
// - reply only when carried ID matches own
// - detect protocol from framing, reply likewise
// - reply: at, ID, header, data, check, terminator
// - check mismatch gives framing-error reply
// - unknown or illegal command gives error reply
// - multidrop form adds prefix and check byte
// - ID read returns header and ID hex
// - station ID kept in nonvolatile storage
// - ID write adopts hex ID, echoes header
// - stored ID ignored for point-to-point commands
// - check byte sent as two hex, high first
// - check field zero zero means unchecked block
`ifndef MHP_DEFS_SVH
`define MHP_DEFS_SVH
// framing characters
`define MHP_CH_AT      8'h40
`define MHP_CH_ENQ     8'h05
`define MHP_CH_STAR    8'h2a
`define MHP_CH_CR      8'h0d
`define MHP_CH_ZERO    8'h30
// command header characters
`define MHP_CH_I       8'h49
`define MHP_CH_R       8'h52
`define MHP_CH_W       8'h57
// headers of the two error replies
`define MHP_FERR_H0    8'h46
`define MHP_FERR_H1    8'h45
`define MHP_CERR_H0    8'h45
`define MHP_CERR_H1    8'h52
// body buffer depth and saturating count limit
`define MHP_BODY_DEPTH 4
`define MHP_CNT_MAX    4'hf
// station ID before the nonvolatile value is loaded
`define MHP_ID_RST     8'h00
// reply slot numbers
`define MHP_SL_AT      4'h0
`define MHP_SL_IDH     4'h1
`define MHP_SL_IDL     4'h2
`define MHP_SL_H0      4'h3
`define MHP_SL_H1      4'h4
`define MHP_SL_D0      4'h5
`define MHP_SL_D1      4'h6
`define MHP_SL_FH      4'h7
`define MHP_SL_FL      4'h8
`define MHP_SL_STAR    4'h9
`define MHP_SL_CR      4'ha
`define MHP_SL_DONE    4'hf
`endif

// ---- rtl/mhp_nv_if.sv ----
// carrier between the parser and the station ID store
`timescale 1ns/100ps
`default_nettype none
interface mhp_nv_if;
   logic       wr_en;   // one-cycle write of a new ID
   logic [7:0] wr_data; // new ID value
   logic [7:0] id;      // current station ID
   modport ctl   (output wr_en, output wr_data, input id);
   modport store (input wr_en, input wr_data, output id);
endinterface
`default_nettype wire

// ---- rtl/mhp_nvid.sv ----
// station ID store mirroring the external nonvolatile cell
`timescale 1ns/100ps
`default_nettype none
`include "mhp_defs.svh"
module mhp_nvid (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  ce,
   input  wire logic [7:0] nv_load_id,
   output logic       nv_store,
   output logic [7:0] nv_store_data,
   mhp_nv_if.store    nv
);
   logic       loaded_q;  // nonvolatile value taken
   logic [7:0] id_q;      // working copy of the ID
   logic       store_q;   // persist strobe
   logic [7:0] sdata_q;   // persisted value

   // copy the stored ID in once after reset, then follow writes
   always_ff @(posedge clk) begin
      if (rst) begin
         loaded_q <= 1'b0;
         id_q     <= `MHP_ID_RST;
         store_q  <= 1'b0;
         sdata_q  <= `MHP_ID_RST;
      end else if (ce) begin
         store_q <= 1'b0;
         if (!loaded_q) begin
            id_q     <= nv_load_id;
            loaded_q <= 1'b1;
         end else if (nv.wr_en) begin
            id_q    <= nv.wr_data;
            store_q <= 1'b1;
            sdata_q <= nv.wr_data;
         end
      end
   end

   assign nv.id         = id_q;
   assign nv_store      = store_q;
   assign nv_store_data = sdata_q;

   // a write reaches the nonvolatile side one enabled cycle later
   nv_persist_a: assert property (@(posedge clk) disable iff (rst)
      (ce && loaded_q && nv.wr_en) |=> (nv_store && nv_store_data == $past(nv.wr_data)))
      else $error("id write not persisted");
endmodule
`default_nettype wire

// ---- rtl/mhp_parser.sv ----
// multidrop host-link command parser, slave side
`timescale 1ns/100ps
`default_nettype none
`include "mhp_defs.svh"
module mhp_parser (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  ce,
   input  wire logic  rx_valid,
   input  wire logic [7:0] rx_data,
   input  wire logic  tx_ready,
   output logic       tx_valid,
   output logic [7:0] tx_data,
   output logic       bus_drive,
   input  wire logic [7:0] nv_load_id,
   output logic       nv_store,
   output logic [7:0] nv_store_data,
   output logic [7:0] station_id
);
   // ascii hex helpers, upper case out, either case in
   function automatic logic hex_ok(input logic [7:0] c);
      hex_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
               || (c >= 8'h61 && c <= 8'h66);
   endfunction
   // a non-hex character yields a meaningless nibble; callers gate with hex_ok
   function automatic logic [3:0] hex_val(input logic [7:0] c);
      logic [7:0] v;
      v = 8'h00;
      if (c <= 8'h39) v = c - 8'h30;
      else if (c <= 8'h46) v = c - 8'h37;
      else v = c - 8'h57;
      hex_val = v[3:0];
   endfunction
   // nibble to upper-case ascii hex digit
   function automatic logic [7:0] to_hex(input logic [3:0] n);
      to_hex = (n < 4'ha) ? ({4'h0, n} + 8'h30) : ({4'h0, n} + 8'h37);
   endfunction
   // next reply slot; point-to-point drops prefix and check byte
   function automatic logic [3:0] nxt_slot(input logic [3:0] s, input logic md,
                                           input logic data);
      logic [3:0] n;
      n = s + 4'h1;
      if (s == `MHP_SL_H1 && !data) n = md ? `MHP_SL_FH : `MHP_SL_STAR;
      if (s == `MHP_SL_D1 && !md) n = `MHP_SL_STAR;
      if (s == `MHP_SL_CR) n = `MHP_SL_DONE;
      nxt_slot = n;
   endfunction

   mhp_nv_if nv ();                       // link to the ID store
   mhp_pkg::mhp_state_e st_q;             // sequencer state
   mhp_pkg::mhp_kind_e  kind_q;           // reply kind latched at decision
   logic        md_q;                     // block came in multidrop form
   logic [7:0]  idh_q, idl_q;             // received station ID chars
   logic [7:0]  body_q [`MHP_BODY_DEPTH]; // header and data chars
   logic [3:0]  cnt_q;                    // body chars, saturating
   logic [7:0]  f1_q, f0_q;               // last two body chars
   logic [7:0]  xa_q, xb_q, xc_q;         // running xor, now and two back
   logic [7:0]  rid_q;                    // ID quoted in the reply
   logic [3:0]  slot_q;                   // next reply slot to load
   logic [3:0]  cur_q;                    // slot of the byte on tx_data
   logic [7:0]  txx_q;                    // xor over reply bytes sent
   logic        txv_q;                    // reply byte offered
   logic [7:0]  txd_q;                    // reply byte
   logic        drv_q;                    // driving the shared bus

   mhp_nvid u_nvid (
      .clk           (clk),
      .rst           (rst),
      .ce            (ce),
      .nv_load_id    (nv_load_id),
      .nv_store      (nv_store),
      .nv_store_data (nv_store_data),
      .nv            (nv.store)
   );

   // receive side decoding
   wire        rx_take  = ce && rx_valid && st_q != mhp_pkg::ST_TX
                          && st_q != mhp_pkg::ST_DEC;
   wire        rx_at    = rx_data == `MHP_CH_AT;
   wire        rx_enq   = rx_data == `MHP_CH_ENQ;
   wire [7:0]  rx_x     = xa_q ^ rx_data;
   wire [3:0]  plen     = md_q ? cnt_q - 4'h2 : cnt_q;
   wire        len_ok   = !md_q || cnt_q >= 4'h2;
   wire        id_match = hex_ok(idh_q) && hex_ok(idl_q)
                          && {hex_val(idh_q), hex_val(idl_q)} == nv.id;
   wire        fcs_skip = f1_q == `MHP_CH_ZERO && f0_q == `MHP_CH_ZERO;
   wire        fcs_ok   = !md_q || fcs_skip || (hex_ok(f1_q) && hex_ok(f0_q)
                          && {hex_val(f1_q), hex_val(f0_q)} == xc_q);
   wire        hdr_i    = body_q[0] == `MHP_CH_I;
   wire        cmd_ir   = len_ok && plen == 4'h2 && hdr_i
                          && body_q[1] == `MHP_CH_R;
   wire        cmd_iw   = len_ok && plen == 4'h4 && hdr_i && body_q[1] == `MHP_CH_W
                          && hex_ok(body_q[2]) && hex_ok(body_q[3]);
   wire        dec      = ce && st_q == mhp_pkg::ST_DEC;
   wire        silent   = md_q && !id_match;
   wire        do_write = dec && !silent && fcs_ok && cmd_iw;
   wire [7:0]  new_id   = {hex_val(body_q[2]), hex_val(body_q[3])};
   mhp_pkg::mhp_kind_e dec_kind;
   assign dec_kind = !fcs_ok ? mhp_pkg::RK_FERR :
                     cmd_ir  ? mhp_pkg::RK_IDRD :
                     cmd_iw  ? mhp_pkg::RK_ECHO : mhp_pkg::RK_CERR;

   // reply side byte selection
   wire        has_data = kind_q == mhp_pkg::RK_IDRD;
   wire        hdr_own  = kind_q == mhp_pkg::RK_ECHO || kind_q == mhp_pkg::RK_IDRD;
   wire [7:0]  rh0 = hdr_own ? body_q[0] :
                     kind_q == mhp_pkg::RK_FERR ? `MHP_FERR_H0 : `MHP_CERR_H0;
   wire [7:0]  rh1 = hdr_own ? body_q[1] :
                     kind_q == mhp_pkg::RK_FERR ? `MHP_FERR_H1 : `MHP_CERR_H1;
   logic [7:0] byte_w;
   always_comb begin
      case (slot_q)
         `MHP_SL_AT:   byte_w = `MHP_CH_AT;
         `MHP_SL_IDH:  byte_w = to_hex(rid_q[7:4]);
         `MHP_SL_IDL:  byte_w = to_hex(rid_q[3:0]);
         `MHP_SL_H0:   byte_w = rh0;
         `MHP_SL_H1:   byte_w = rh1;
         `MHP_SL_D0:   byte_w = to_hex(rid_q[7:4]);
         `MHP_SL_D1:   byte_w = to_hex(rid_q[3:0]);
         `MHP_SL_FH:   byte_w = to_hex(txx_q[7:4]);
         `MHP_SL_FL:   byte_w = to_hex(txx_q[3:0]);
         `MHP_SL_STAR: byte_w = `MHP_CH_STAR;
         `MHP_SL_CR:   byte_w = `MHP_CH_CR;
         default:      byte_w = 8'h00;
      endcase
   end
   // a new byte is loaded only once the previous one was accepted
   wire tx_free = !txv_q || tx_ready;
   wire tx_load = ce && st_q == mhp_pkg::ST_TX && tx_free && slot_q != `MHP_SL_DONE;
   wire tx_end  = ce && st_q == mhp_pkg::ST_TX && tx_free && slot_q == `MHP_SL_DONE;

   // sequencer: a start character resynchronises reception, except while deciding or replying
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= mhp_pkg::ST_IDLE;
      end else if (rx_take && rx_at) begin
         st_q <= mhp_pkg::ST_ID_HI;
      end else if (rx_take && rx_enq) begin
         st_q <= mhp_pkg::ST_BODY;
      end else if (rx_take) begin
         case (st_q)
            mhp_pkg::ST_ID_HI: st_q <= mhp_pkg::ST_ID_LO;
            mhp_pkg::ST_ID_LO: st_q <= mhp_pkg::ST_BODY;
            mhp_pkg::ST_BODY: begin
               if (rx_data == `MHP_CH_STAR) st_q <= mhp_pkg::ST_END;
            end
            mhp_pkg::ST_END: begin
               // only a complete block is answered
               st_q <= (rx_data == `MHP_CH_CR) ? mhp_pkg::ST_DEC
                                               : mhp_pkg::ST_IDLE;
            end
            // a byte outside any block is dropped
            default: st_q <= mhp_pkg::ST_IDLE;
         endcase
      end else if (dec) begin
         st_q <= silent ? mhp_pkg::ST_IDLE : mhp_pkg::ST_TX;
      end else if (tx_end) begin
         st_q <= mhp_pkg::ST_IDLE;
      end
   end

   // framing capture: form, ID chars and protocol flag
   always_ff @(posedge clk) begin
      if (rst) begin
         md_q  <= 1'b0;
         idh_q <= 8'h00;
         idl_q <= 8'h00;
      end else if (rx_take) begin
         if (rx_at) md_q <= 1'b1;
         else if (rx_enq) md_q <= 1'b0;
         // ID chars are kept raw; they are decoded only at the decision
         if (st_q == mhp_pkg::ST_ID_HI && !rx_at && !rx_enq) idh_q <= rx_data;
         if (st_q == mhp_pkg::ST_ID_LO && !rx_at && !rx_enq) idl_q <= rx_data;
      end
   end

   // body capture with running xor and its two-back history
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 4'h0;
         f1_q  <= 8'h00;
         f0_q  <= 8'h00;
         xa_q  <= 8'h00;
         xb_q  <= 8'h00;
         xc_q  <= 8'h00;
         for (int i = 0; i < `MHP_BODY_DEPTH; i++) body_q[i] <= 8'h00;
      end else if (rx_take && (rx_at || rx_enq)) begin
         // a start character opens a fresh block and a fresh xor
         cnt_q <= 4'h0;
         xa_q  <= rx_at ? rx_data : 8'h00;
         xb_q  <= 8'h00;
         xc_q  <= 8'h00;
      end else if (rx_take && (st_q == mhp_pkg::ST_ID_HI || st_q == mhp_pkg::ST_ID_LO)) begin
         xa_q <= rx_x;
         xb_q <= xa_q;
         xc_q <= xb_q;
      end else if (rx_take && st_q == mhp_pkg::ST_BODY && rx_data != `MHP_CH_STAR) begin
         // chars past the buffer are only counted, not stored; a multidrop write puts its check chars there
         if (cnt_q < 4'(`MHP_BODY_DEPTH)) body_q[cnt_q[1:0]] <= rx_data;
         if (cnt_q != `MHP_CNT_MAX) cnt_q <= cnt_q + 4'h1;
         f1_q <= f0_q;
         f0_q <= rx_data;
         xa_q <= rx_x;
         xb_q <= xa_q;
         xc_q <= xb_q;
      end
   end

   // decision latch and reply generation
   always_ff @(posedge clk) begin
      if (rst) begin
         kind_q <= mhp_pkg::RK_ECHO;
         rid_q  <= 8'h00;
         slot_q <= `MHP_SL_DONE;
         cur_q  <= `MHP_SL_DONE;
         txx_q  <= 8'h00;
         txv_q  <= 1'b0;
         txd_q  <= 8'h00;
         drv_q  <= 1'b0;
      end else if (dec) begin
         kind_q <= dec_kind;
         // the reply quotes the ID held before any write in this block
         rid_q  <= nv.id;
         slot_q <= md_q ? `MHP_SL_AT : `MHP_SL_H0;
         txx_q  <= 8'h00;
         drv_q  <= !silent;
      end else if (tx_load) begin
         txv_q  <= 1'b1;
         txd_q  <= byte_w;
         cur_q  <= slot_q;
         slot_q <= nxt_slot(slot_q, md_q, has_data);
         // prefix, header and data feed the reply check; the check does not
         if (slot_q < `MHP_SL_FH) txx_q <= txx_q ^ byte_w;
      end else if (tx_end) begin
         txv_q <= 1'b0;
         cur_q <= `MHP_SL_DONE;
         drv_q <= 1'b0;
      end
   end

   // every top-level output comes straight from a flip-flop
   assign nv.wr_en    = do_write;
   assign nv.wr_data  = new_id;
   assign tx_valid    = txv_q;
   assign tx_data     = txd_q;
   assign bus_drive   = drv_q;
   assign station_id  = nv.id;

   // checks on the decision cycle and on what reaches the pins
   drive_cover_a: assert property (@(posedge clk) disable iff (rst)
      tx_valid |-> bus_drive)
      else $error("reply byte offered while bus released");
   mismatch_quiet_a: assert property (@(posedge clk) disable iff (rst)
      (dec && md_q && !id_match) |=> (st_q == mhp_pkg::ST_IDLE && !bus_drive))
      else $error("reply to foreign station id");
   reply_start_a: assert property (@(posedge clk) disable iff (rst)
      $rose(bus_drive) |-> $past(st_q == mhp_pkg::ST_DEC))
      else $error("bus taken before terminator");
   fcs_error_a: assert property (@(posedge clk) disable iff (rst)
      (dec && md_q && id_match && !fcs_ok) |=> kind_q == mhp_pkg::RK_FERR)
      else $error("bad check byte not reported");
   // a store pulse only ever sits inside an echo reply, never a framing error
   no_exec_a: assert property (@(posedge clk) disable iff (rst)
      nv_store |-> (kind_q == mhp_pkg::RK_ECHO && st_q == mhp_pkg::ST_TX))
      else $error("id written without valid block");
   first_at_a: assert property (@(posedge clk) disable iff (rst)
      ($rose(tx_valid) && md_q) |-> tx_data == `MHP_CH_AT)
      else $error("multidrop reply not led by at-sign");
   p2p_form_a: assert property (@(posedge clk) disable iff (rst)
      (tx_valid && !md_q) |-> (cur_q >= `MHP_SL_H0 && cur_q != `MHP_SL_FH
                               && cur_q != `MHP_SL_FL))
      else $error("point-to-point reply carries prefix or check");
   id_digits_a: assert property (@(posedge clk) disable iff (rst)
      (tx_valid && cur_q == `MHP_SL_D0) |-> (tx_data == to_hex(rid_q[7:4])
                                             && kind_q == mhp_pkg::RK_IDRD))
      else $error("id read data wrong");
   fcs_send_a: assert property (@(posedge clk) disable iff (rst)
      (tx_valid && cur_q == `MHP_SL_FH) |-> tx_data == to_hex(txx_q[7:4]))
      else $error("reply check byte wrong");
   // a zero-zero check field must never turn into a framing error reply
   skip_check_a: assert property (@(posedge clk) disable iff (rst)
      (dec && md_q && fcs_skip && !silent) |=> kind_q != mhp_pkg::RK_FERR)
      else $error("zero check field rejected");
   cmd_error_a: assert property (@(posedge clk) disable iff (rst)
      (dec && fcs_ok && !cmd_ir && !cmd_iw && !silent) |=> kind_q == mhp_pkg::RK_CERR)
      else $error("unknown command not refused");
   end_release_a: assert property (@(posedge clk) disable iff (rst)
      tx_end |=> !bus_drive)
      else $error("bus held after terminator");
   // with the enable low nothing at the pins may move
   freeze_hold_a: assert property (@(posedge clk) disable iff (rst)
      !ce |=> ($stable(tx_valid) && $stable(tx_data) && $stable(bus_drive)))
      else $error("outputs moved while clock enable low");

   // main scenarios: point-to-point reply, ID read, framing error, a write and the silent case
   p2p_reply_c: cover property (@(posedge clk) disable iff (rst) $rose(tx_valid) && !md_q);
   id_read_c:  cover property (@(posedge clk) disable iff (rst)
      dec && !silent && dec_kind == mhp_pkg::RK_IDRD);
   id_write_c: cover property (@(posedge clk) disable iff (rst) nv.wr_en && md_q);
   ferr_c:     cover property (@(posedge clk) disable iff (rst)
      dec && md_q && id_match && !fcs_ok);
   quiet_c:    cover property (@(posedge clk) disable iff (rst) dec && silent);
endmodule
`default_nettype wire

// ---- rtl/mhp_pkg.sv ----
// types of the multidrop host-link command parser
package mhp_pkg;
   // receive and reply sequencing
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ID_HI = 3'b001,
      ST_ID_LO = 3'b010,
      ST_BODY  = 3'b011,
      ST_END   = 3'b100,
      ST_DEC   = 3'b101,
      ST_TX    = 3'b110
   } mhp_state_e;
   // kind of reply being sent
   typedef enum logic [1:0] {
      RK_ECHO = 2'b00,
      RK_IDRD = 2'b01,
      RK_FERR = 2'b10,
      RK_CERR = 2'b11
   } mhp_kind_e;
endpackage

// ---- tb/mhp_host.sv ----
// host-side model: sends command blocks and collects reply bytes
`timescale 1ns/100ps
`default_nettype none
module mhp_host (
   input  wire logic       clk,
   input  wire logic       ce,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       bus_drive,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            tx_ready
);
   logic [7:0] rep[$];   // reply bytes taken so far
   logic       sending;  // a command block is on the wire
   logic [1:0] phase;    // stall pattern counter

   // quiet line and an open reply path at time zero
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b1;
      sending  = 1'b0;
      phase    = 2'h0;
   end

   // reply path: ready every cycle, or one cycle in three when slow
   always @(negedge clk) begin
      phase    <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      tx_ready <= !slow || (phase == 2'h2);
   end

   // take a byte on the handshake edge; every byte is kept for inspection
   always @(posedge clk) begin
      if (tx_valid && tx_ready && ce && bus_drive) begin
         rep.push_back(tx_data);
      end
   end

   // single master: a block goes out only while no station holds the bus
   task automatic send(input logic [7:0] blk[$]);
      @(negedge clk);
      while (bus_drive) begin
         @(negedge clk);
      end
      sending = 1'b1;
      foreach (blk[i]) begin
         rx_valid <= 1'b1;
         rx_data  <= blk[i];
         @(negedge clk);
      end
      rx_valid <= 1'b0;
      // released line: never leave the last byte standing
      rx_data  <= ~rx_data;
      sending = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench of the multidrop host-link command parser
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef logic [7:0] mhp_bq_t[$];
   logic       clk = 1'b0;    // 25 MHz clock
   logic       rst;           // synchronous reset
   logic       ce = 1'b1;     // clock enable, frozen at random in replies
   logic       slow;          // host stalls the reply path
   logic       rx_valid;      // byte from host
   logic [7:0] rx_data;       // host character
   logic       tx_ready;      // host accepts reply byte
   logic       tx_valid;      // reply byte offered
   logic [7:0] tx_data;       // reply character
   logic       bus_drive;     // driver enable
   logic [7:0] nv_load_id;    // nonvolatile cell content
   logic       nv_store;      // write pulse to the cell
   logic [7:0] nv_store_data; // value to persist
   logic [7:0] station_id;    // current ID
   int         failures;
   int         n_checks;
   int         seed;
   int         cycles;
   int         stores;        // write pulses seen
   logic [7:0] stored;        // last value persisted
   logic [7:0] my_id;         // ID the bench expects
   logic [7:0] id;
   logic [7:0] nid;
   int         mode;
   mhp_bq_t    none;          // empty reply: silence

   mhp_parser u_mhp_parser (.clk(clk), .rst(rst), .ce(ce), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .bus_drive(bus_drive), .nv_load_id(nv_load_id), .nv_store(nv_store),
      .nv_store_data(nv_store_data), .station_id(station_id));
   mhp_host u_mhp_host (.clk(clk), .ce(ce), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
      .bus_drive(bus_drive), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));

   // free-running clock, 40 ns period
   initial begin
      forever #20 clk = ~clk;
   end

   // watchdog, store pulse tracking and no reply while a block is arriving
   always @(posedge clk) begin
      cycles++;
      if (nv_store === 1'b1 && ce === 1'b1) begin
         stores++;
         stored = nv_store_data;
      end
      if (tx_valid === 1'b1 && u_mhp_host.sending) begin
         failures++;
         $display("Error at %0t: reply %h during command", $time, tx_data);
      end
      if (cycles > 20000) begin
         failures++;
         give_verdict();
      end
   end

   // random freezes of one cycle or more, only while a reply owns the bus
   always @(negedge clk) begin
      ce <= rst || !bus_drive || (($random(seed) & 3) != 0);
   end

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // length first, then every byte in order
   task automatic check_reply(input mhp_bq_t got, input mhp_bq_t exp);
      check8(8'(got.size()), 8'(exp.size()));
      foreach (exp[i]) check8((i < got.size()) ? got[i] : 8'hxx, exp[i]);
   endtask

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   // multidrop block; mode 0 checked, 1 check field zero zero, 2 corrupted check
   function automatic mhp_bq_t md(input logic [7:0] i, input mhp_bq_t body, input int m);
      mhp_bq_t    q;
      logic [7:0] f;
      q = {8'h40, hx(i[7:4]), hx(i[3:0])};
      q = {q, body};
      f = 8'h00;
      foreach (q[k]) f ^= q[k];
      if (m == 1) f = 8'h00;
      if (m == 2) f = (f == 8'h5a) ? 8'h11 : f ^ 8'h5a;
      q = {q, hx(f[7:4]), hx(f[3:0]), 8'h2a, 8'h0d};
      return q;
   endfunction

   // send one block, wait for the reply to end or for silence
   task automatic run(input mhp_bq_t cmd, input mhp_bq_t exp);
      int k;
      u_mhp_host.rep.delete();
      u_mhp_host.send(cmd);
      k = 0;
      while (k < 400 && !(k > 30 && bus_drive === 1'b0 &&
             (exp.size() == 0 || u_mhp_host.rep.size() > 0))) begin
         @(negedge clk);
         k++;
      end
      check_reply(u_mhp_host.rep, exp);
   endtask

   task automatic give_verdict;
      if (failures == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // main sequence: corner cases first, then random traffic
   initial begin
      failures = 0;
      n_checks = 0;
      cycles = 0;
      stores = 0;
      stored = 8'h00;
      seed = 75747;
      rst = 1'b1;
      slow = 1'b0;
      nv_load_id = 8'($random(seed));
      my_id = nv_load_id;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      check8(station_id, my_id);
      run(md(my_id, {8'h49, 8'h52}, 0),
          md(my_id, {8'h49, 8'h52, hx(my_id[7:4]), hx(my_id[3:0])}, 0));
      run(md(my_id, {8'h49, 8'h52}, 1),
          md(my_id, {8'h49, 8'h52, hx(my_id[7:4]), hx(my_id[3:0])}, 0));
      run(md(my_id, {8'h49, 8'h52}, 2), md(my_id, {8'h46, 8'h45}, 0));
      run(md(my_id, {8'h51, 8'h5a}, 0), md(my_id, {8'h45, 8'h52}, 0));
      run(md(my_id ^ 8'h01, {8'h49, 8'h52}, 0), none);
      run(md(my_id ^ 8'h80, {8'h49, 8'h52}, 2), none);
      run({8'h05, 8'h49, 8'h52, 8'h2a, 8'h0d},
          {8'h49, 8'h52, hx(my_id[7:4]), hx(my_id[3:0]), 8'h2a, 8'h0d});
      run({8'h05, 8'h51, 8'h5a, 8'h2a, 8'h0d}, {8'h45, 8'h52, 8'h2a, 8'h0d});
      nid = my_id + 8'h5b;
      run(md(my_id, {8'h49, 8'h57, hx(nid[7:4]), hx(nid[3:0])}, 2),
          md(my_id, {8'h46, 8'h45}, 0));
      check8(station_id, my_id);
      check8(stores[7:0], 8'h00);
      slow = 1'b1;
      run(md(my_id, {8'h49, 8'h57, hx(nid[7:4]), hx(nid[3:0])}, 0),
          md(my_id, {8'h49, 8'h57}, 0));
      check8(station_id, nid);
      check8(stored, nid);
      check8(stores[7:0], 8'h01);
      my_id = nid;
      for (int n = 0; n < 12; n++) begin
         slow = 1'($random(seed));
         mode = $random(seed) & 1;
         id = ($random(seed) & 1) ? my_id : 8'($random(seed));
         if (id == my_id) begin
            run(md(id, {8'h49, 8'h52}, mode),
                md(id, {8'h49, 8'h52, hx(id[7:4]), hx(id[3:0])}, 0));
         end else begin
            run(md(id, {8'h49, 8'h52}, mode), none);
         end
      end
      give_verdict();
   end
endmodule
`default_nettype wire
